/* File: rtl/pic_top.sv */
// APB interrupt controller: pending bits, global enable, priority and core handshake
// Contract
// - Enable, return-from-interrupt or a written 1 sets the global enable flag.
// - Disable, acknowledge, a written 0, reset and every trap clear the global enable flag.
// - Each source can be put at level 1, 2 or 3, with 3 the highest.
// - A higher-level pending request that is enabled or forced always beats a lower-level one.
// - Inside one level a fixed source order picks the winner.
// - Forced sources such as the watchdog always sit at the top level.
// - A request pulse sets the source's pending bit.
// - Acknowledge clears the winner's pending bit until the next pulse.
// - Writing 0 to a pending bit clears it.
// - Only with the global flag set is the winner forwarded; otherwise bits are polled.
// - Serial receive, serial transmit and converter bits read 1 while pending.
`timescale 1ns/1ps
`include "pic_cfg.svh"
module pic_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] src_pulse,
  input wire logic [15:0] force_top,
  input wire pic_pkg::pic_core_ev_t core_ev,
  output logic irq_req,
  output logic [3:0] irq_src,
  output logic [1:0] irq_level,
  input wire logic irq_ack,
  output logic global_irq_enable_bit
);
  logic [15:0] req_r;
  logic [15:0] en_r;
  logic [15:0] lvl_lo_r;
  logic [15:0] lvl_hi_r;
  logic global_irq_enable_bit_r;
  logic [31:0] rdata_nxt;
  logic [15:0] req_clr;
  pic_pkg::pic_winner_t win;
  pic_pkg::pic_state_t st_r;
  logic wr;
  logic wr_ctrl;
  logic wr_req;
  logic wr_en;
  logic wr_lo;
  logic wr_hi;
  logic ack_ok;
  logic trap_any;
  logic global_irq_enable_bit_clr;
  logic global_irq_enable_bit_set;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // Unmapped offsets answer with an error and read as zero
  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `PIC_OFS_CTRL) || hit(a, `PIC_OFS_REQ) || hit(a, `PIC_OFS_EN) ||
             hit(a, `PIC_OFS_LVLLO) || hit(a, `PIC_OFS_LVLHI) || hit(a, `PIC_OFS_STAT);
  endfunction

  // Single-cycle APB slave: every access completes in its first access cycle
  assign wr = psel && penable && pwrite && pstrb[0];
  // No wait states, so ready is a constant
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  // One write strobe per register keeps the update processes small
  assign wr_ctrl = wr && hit(paddr, `PIC_OFS_CTRL);
  assign wr_req = wr && hit(paddr, `PIC_OFS_REQ);
  assign wr_en = wr && hit(paddr, `PIC_OFS_EN);
  assign wr_lo = wr && hit(paddr, `PIC_OFS_LVLLO);
  assign wr_hi = wr && hit(paddr, `PIC_OFS_LVLHI);

  pic_arbiter u_arb (
    .pending(req_r),
    .enable(en_r),
    .lvl_lo(lvl_lo_r),
    .lvl_hi(lvl_hi_r),
    .force_top(force_top),
    .winner(win)
  );

  // Acknowledge only counts while a request is actually shown to the core
  assign ack_ok = irq_ack && irq_req;

  // Clear mask for the pending bits: software zeros and the acknowledged source
  always_comb begin
    req_clr = 16'h0000;
    if (wr_req) begin
      req_clr = ~pwdata[15:0];
    end
    if (ack_ok) begin
      req_clr[irq_src] = 1'b1;
    end
  end

  // Pending bits; a new pulse beats a same-cycle clear so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= `PIC_RST_REQ;
    end else begin
      req_r <= (req_r & ~req_clr) | src_pulse;
    end
  end

  // Writing 1 to a pending bit cannot set it: only sources raise requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= `PIC_RST_EN;
      lvl_lo_r <= `PIC_RST_LVL;
      lvl_hi_r <= `PIC_RST_LVL;
    end else begin
      if (wr_en) begin
        en_r <= pwdata[15:0];
      end
      if (wr_lo) begin
        lvl_lo_r <= pwdata[15:0];
      end
      if (wr_hi) begin
        lvl_hi_r <= pwdata[15:0];
      end
    end
  end

  // Every trap drops the flag so a handler never nests by accident
  assign trap_any = core_ev.trap_instruction || core_ev.illegal_trap || core_ev.primary_osc_fail_trap ||
                    core_ev.watchdog_osc_fail_trap;
  assign global_irq_enable_bit_clr = core_ev.disable_irq_instruction || ack_ok || trap_any ||
                    (wr_ctrl && !pwdata[`PIC_CTRL_GLOBAL_IRQ_ENABLE_BIT_BIT]);
  assign global_irq_enable_bit_set = core_ev.enable_irq_instruction || core_ev.return_from_irq_instruction ||
                    (wr_ctrl && pwdata[`PIC_CTRL_GLOBAL_IRQ_ENABLE_BIT_BIT]);

  // Global enable; any clearing event beats a setting one in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable_bit_r <= 1'b0;
    end else if (global_irq_enable_bit_clr) begin
      global_irq_enable_bit_r <= 1'b0;
    end else if (global_irq_enable_bit_set) begin
      global_irq_enable_bit_r <= 1'b1;
    end
  end

  // Core handshake: the request and its source stay frozen until acknowledged, cleared by software or the flag drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= pic_pkg::PIC_ST_IDLE;
      irq_req <= 1'b0;
      irq_src <= 4'h0;
      irq_level <= 2'h0;
    end else begin
      case (st_r)
        pic_pkg::PIC_ST_IDLE: begin
          if (global_irq_enable_bit_r && win.valid) begin
            st_r <= pic_pkg::PIC_ST_REQ;
            irq_req <= 1'b1;
            irq_src <= win.src;
            irq_level <= win.level;
          end
        end
        pic_pkg::PIC_ST_REQ: begin
          if (ack_ok) begin
            st_r <= pic_pkg::PIC_ST_WAIT;
            irq_req <= 1'b0;
          end else if (!req_r[irq_src]) begin
            // Software cleared the shown request before the core took it
            st_r <= pic_pkg::PIC_ST_IDLE;
            irq_req <= 1'b0;
          end else if (!global_irq_enable_bit_r) begin
            // Flag dropped while shown: back to polling, the bit stays pending
            st_r <= pic_pkg::PIC_ST_IDLE;
            irq_req <= 1'b0;
          end
        end
        pic_pkg::PIC_ST_WAIT: begin
          // Spacer cycle after an ack before the next pick
          st_r <= pic_pkg::PIC_ST_IDLE;
        end
        default: begin
          st_r <= pic_pkg::PIC_ST_IDLE;
          irq_req <= 1'b0;
        end
      endcase
    end
  end

  // The flag is visible to the core as a plain level
  assign global_irq_enable_bit = global_irq_enable_bit_r;

  // Read mux; the status word shows the current winner even while the flag is clear
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      `PIC_OFS_CTRL: rdata_nxt[`PIC_CTRL_GLOBAL_IRQ_ENABLE_BIT_BIT] = global_irq_enable_bit_r;
      `PIC_OFS_REQ: rdata_nxt[15:0] = req_r;
      `PIC_OFS_EN: rdata_nxt[15:0] = en_r;
      `PIC_OFS_LVLLO: rdata_nxt[15:0] = lvl_lo_r;
      `PIC_OFS_LVLHI: rdata_nxt[15:0] = lvl_hi_r;
      `PIC_OFS_STAT: rdata_nxt = {24'h0, win.valid, 1'b0, win.level, win.src};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data registered at setup so it is stable in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end
endmodule

/* File: rtl/pic_cfg.svh */
// Register offsets, field positions, reset values and sizes for the interrupt controller
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
`define PIC_NSRC 16
`define PIC_OFS_CTRL 12'h000
`define PIC_OFS_REQ 12'h004
`define PIC_OFS_EN 12'h008
`define PIC_OFS_LVLLO 12'h00c
`define PIC_OFS_LVLHI 12'h010
`define PIC_OFS_STAT 12'h014
`define PIC_CTRL_GLOBAL_IRQ_ENABLE_BIT_BIT 7
`define PIC_SRC_SERIAL_RX 5
`define PIC_SRC_SERIAL_TX 4
`define PIC_SRC_CONVERTER 0
`define PIC_RST_CTRL 32'h0000_0000
`define PIC_RST_REQ 16'h0000
`define PIC_RST_EN 16'h0000
`define PIC_RST_LVL 16'h0000
`endif

/* File: rtl/pic_pkg.sv */
// Types shared by the interrupt controller files
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_LVL_OFF = 2'b00,
    PIC_LVL_1 = 2'b01,
    PIC_LVL_2 = 2'b10,
    PIC_LVL_3 = 2'b11
  } pic_level_t;

  typedef struct packed {
    logic enable_irq_instruction;
    logic disable_irq_instruction;
    logic return_from_irq_instruction;
    logic trap_instruction;
    logic illegal_trap;
    logic primary_osc_fail_trap;
    logic watchdog_osc_fail_trap;
  } pic_core_ev_t;

  typedef struct packed {
    logic valid;
    logic [3:0] src;
    pic_level_t level;
  } pic_winner_t;

  typedef enum logic [1:0] {
    PIC_ST_IDLE = 2'b00,
    PIC_ST_REQ = 2'b01,
    PIC_ST_WAIT = 2'b10
  } pic_state_t;
endpackage

/* File: rtl/pic_arbiter.sv */
// Three-level priority arbiter with fixed source order inside each level
`timescale 1ns/1ps
module pic_arbiter (
  input wire logic [15:0] pending,
  input wire logic [15:0] enable,
  input wire logic [15:0] lvl_lo,
  input wire logic [15:0] lvl_hi,
  input wire logic [15:0] force_top,
  output pic_pkg::pic_winner_t winner
);
  logic [1:0] eff [16];

  // Level of a source; forced sources always sit at the top level
  function automatic logic [1:0] src_level(input logic hi, input logic lo, input logic top);
    src_level = top ? 2'b11 : {hi, lo};
  endfunction

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_lvl
      assign eff[g] = (pending[g] && (enable[g] || force_top[g])) ?
                      src_level(lvl_hi[g], lvl_lo[g], force_top[g]) : 2'b00;
    end
  endgenerate

  // Higher level wins; equal level goes to the higher source index
  always_comb begin
    winner = '0;
    for (int i = 0; i < 16; i++) begin
      if (eff[i] != 2'b00 && (!winner.valid || eff[i] >= 2'(winner.level))) begin
        winner.valid = 1'b1;
        winner.src = 4'(i);
        winner.level = pic_pkg::pic_level_t'(eff[i]);
      end
    end
  end
endmodule

/* File: test/pic_top_sva.sv */
// Port assertions for the interrupt controller
`timescale 1ns/1ps
module pic_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire pic_pkg::pic_core_ev_t core_ev,
  input wire logic [15:0] force_top,
  input wire logic irq_req,
  input wire logic [3:0] irq_src,
  input wire logic [1:0] irq_level,
  input wire logic irq_ack,
  input wire logic global_irq_enable_bit
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Clear events win a tie, so the set check excludes them
  AST_SET: assert property ((core_ev == 7'h40 || core_ev == 7'h10) && !irq_ack && !psel |=> global_irq_enable_bit)
    else $error("flag not set");
  AST_DIS: assert property (core_ev.disable_irq_instruction |=> !global_irq_enable_bit)
    else $error("flag not cleared");
  AST_TRAP: assert property (|core_ev[3:0] |=> !global_irq_enable_bit)
    else $error("trap kept flag");
  AST_ACK: assert property (irq_req && irq_ack |=> !irq_req && !global_irq_enable_bit ##1 !irq_req)
    else $error("ack not honoured");
  AST_HOLD: assert property (irq_req && !irq_ack && !psel && global_irq_enable_bit |=> irq_req && $stable(irq_src))
    else $error("request dropped");
  AST_WDRAW: assert property (irq_req && !irq_ack && !global_irq_enable_bit |=> !irq_req)
    else $error("request kept while disabled");
  AST_POLL: assert property (!global_irq_enable_bit && !irq_req |=> !irq_req)
    else $error("forwarded while disabled");
  AST_LVL: assert property (irq_req |-> irq_level != 2'b00)
    else $error("bad level");
  AST_TOP: assert property (irq_req && force_top[irq_src] |-> irq_level == 2'b11)
    else $error("forced source not top");
endmodule
bind pic_top pic_top_sva i_pic_top_sva (.pclk, .presetn, .psel, .core_ev, .force_top, .irq_req,
  .irq_src, .irq_level, .irq_ack, .global_irq_enable_bit);

/* File: test/pic_core_model.sv */
// Core stand-in that acknowledges forwarded requests
`timescale 1ns/1ps
module pic_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic [3:0] irq_src,
  input wire logic [3:0] dly,
  output logic irq_ack,
  output logic [3:0] last_src,
  output logic [7:0] served
);
  logic [3:0] wait_r;
  // A slow core lets dly cycles pass before the one-cycle ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      wait_r <= 4'h0;
      last_src <= 4'h0;
      served <= 8'h00;
    end else begin
      irq_ack <= irq_req && !irq_ack && wait_r == dly;
      wait_r <= (irq_req && !irq_ack && wait_r != dly) ? wait_r + 4'h1 : 4'h0;
      if (irq_req && !irq_ack && wait_r == dly) begin
        last_src <= irq_src;
        served <= served + 8'h01;
      end
    end
  end
endmodule

/* File: test/pic_bench.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "pic_cfg.svh"
module pic_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req, irq_ack, flag, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] src_pulse, force_top;
  logic [3:0] irq_src, dly, last_src;
  logic [1:0] irq_level;
  logic [7:0] served;
  pic_pkg::pic_core_ev_t core_ev;
  int err_total, samples_checked;
  pic_top i_pic_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
    .pslverr, .src_pulse, .force_top, .core_ev, .irq_req, .irq_src, .irq_level, .irq_ack, .global_irq_enable_bit(flag));
  pic_core_model i_pic_core_model (.pclk, .presetn, .irq_req, .irq_src, .dly, .irq_ack, .last_src, .served);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task ev(input logic [6:0] e);
    core_ev <= e;
    @(posedge pclk);
    core_ev <= 7'h00;
    @(posedge pclk);
  endtask
  task pulse(input logic [15:0] m);
    src_pulse <= m;
    @(posedge pclk);
    src_pulse <= 16'h0000;
    @(posedge pclk);
  endtask
  task serve(input logic [3:0] s);
    logic [7:0] n;
    n = served;
    repeat (40) if (served == n) @(posedge pclk);
    chk(served, n + 8'h01);
    chk(last_src, s);
    repeat (2) @(posedge pclk);
    chk(flag, 1'b0);
  endtask
  task t_poll;
    apb(0, `PIC_OFS_CTRL, 0);
    chk(rd, `PIC_RST_CTRL);
    apb(0, 12'h100, 0);
    chk(se, 1'b1);
    pulse(16'h0031);
    pulse(16'h0020);
    apb(0, `PIC_OFS_REQ, 0);
    chk(rd, 32'h31);
    chk(irq_req, 1'b0);
    apb(1, `PIC_OFS_REQ, 32'hffee);
    apb(0, `PIC_OFS_REQ, 0);
    chk(rd, 32'h20);
    apb(1, `PIC_OFS_REQ, 0);
  endtask
  task t_prio;
    apb(1, `PIC_OFS_EN, 32'hffff);
    apb(1, `PIC_OFS_LVLLO, 32'h21);
    apb(1, `PIC_OFS_LVLHI, 32'h91);
    pulse(16'h00b1);
    apb(1, `PIC_OFS_CTRL, 32'h80);
    serve(4'h0);
    ev(7'h40);
    serve(4'h7);
    dly <= 4'h3;
    ev(7'h10);
    serve(4'h4);
    apb(1, `PIC_OFS_CTRL, 32'h80);
    serve(4'h5);
    apb(0, `PIC_OFS_REQ, 0);
    chk(rd, 32'h0);
  endtask
  task t_top;
    apb(1, `PIC_OFS_EN, 32'h200);
    apb(1, `PIC_OFS_LVLLO, 32'h200);
    force_top <= 16'h0004;
    pulse(16'h0204);
    apb(1, `PIC_OFS_CTRL, 32'h80);
    serve(4'h2);
    chk(irq_level, 2'h3);
    ev(7'h40);
    serve(4'h9);
    chk(irq_level, 2'h1);
    force_top <= 16'h0000;
  endtask
  task t_flag;
    dly <= 4'hf;
    pulse(16'h0200);
    ev(7'h40);
    ev(7'h20);
    @(posedge pclk);
    chk(irq_req, 1'b0);
    apb(0, `PIC_OFS_REQ, 0);
    chk(rd, 32'h200);
    apb(1, `PIC_OFS_REQ, 0);
    dly <= 4'h0;
    for (int i = 0; i < 6; i++) begin
      ev(7'h40);
      chk(flag, 1'b1);
      ev(7'h01 << i);
      chk(flag, i == 4);
    end
    apb(1, `PIC_OFS_CTRL, 32'h80);
    apb(1, `PIC_OFS_CTRL, 32'h0);
    chk(flag, 1'b0);
  endtask
  task report_and_stop;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {src_pulse, force_top, core_ev, dly} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_poll;
    t_prio;
    t_top;
    t_flag;
    report_and_stop;
  end
  // Whole run needs fewer than 200 cycles
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    report_and_stop;
  end
endmodule
